// >>> src/pmcs_pkg.sv
// Constants for the power-mode and device-clock selector.
// Assumes a 100 MHz pclk and an APB register port with 32-bit data.
package pmcs_pkg;
  // Register byte addresses
  localparam logic [7:0] OSC_CTRL_ADDR    = 8'h00;
  localparam logic [7:0] TIMER1_CTRL_ADDR = 8'h04;
  localparam logic [7:0] CONFIG_ADDR      = 8'h08;
  localparam logic [7:0] STATUS_ADDR      = 8'h0C;
  // Control register fields
  localparam int IDLE_EN_POS   = 7;
  localparam int FREQ_LSB      = 4;
  localparam int PRI_RDY_POS   = 3;
  localparam int INT_STB_POS   = 2;
  localparam int SEC_OSC_EN_POS = 3;
  localparam int SECONDARY_RUN_MODE_POS   = 6;
  localparam int POWER_UP_DELAY_TIMER_EN_N_POS = 4;
  localparam int WDT_EN_POS    = 5;
  // Reset values
  localparam logic [2:0] FREQ_RESET      = 3'h4;
  localparam logic [1:0] SEL_RESET       = 2'h0;
  localparam logic [3:0] CFG_OSC_RESET   = 4'h2;
  localparam logic       POWER_UP_DELAY_TIMER_EN_N_RESET = 1'b1;
  localparam logic       WDT_EN_RESET    = 1'b0;
  // Source codes
  localparam logic [1:0] SRC_PRI = 2'h0;
  localparam logic [1:0] SRC_SEC = 2'h1;
  localparam logic [1:0] SRC_INT = 2'h2;
  localparam logic [2:0] FREQ_SLOW  = 3'h0;
  // Primary oscillator configuration codes
  localparam logic [3:0] OSC_LP     = 4'h0;
  localparam logic [3:0] OSC_XT     = 4'h1;
  localparam logic [3:0] OSC_HS     = 4'h2;
  localparam logic [3:0] OSC_HIGH_SPEED_PLL_MODE  = 4'h6;
  localparam logic [3:0] OSC_EC     = 4'h4;
  localparam logic [3:0] OSC_EXTERNAL_CLOCK_IO_MODE   = 4'h5;
  localparam logic [3:0] OSC_RC     = 4'h3;
  localparam logic [3:0] OSC_RESISTOR_CAPACITOR_IO_MODE   = 4'h7;
  localparam logic [3:0] OSC_INTERNAL_ALL_IO_MODE = 4'h8;
  localparam logic [3:0] OSC_INTERNAL_CLOCKOUT_MODE = 4'h9;
  // Timing
  localparam int CLK_MHZ      = 100;
  localparam int PLL_LOCK_US  = 2000;
  localparam int PLL_CYC      = PLL_LOCK_US * CLK_MHZ;
  localparam int POWER_UP_DELAY_TIMER_US      = 65;
  localparam int POWER_UP_DELAY_TIMER_CYC     = POWER_UP_DELAY_TIMER_US * CLK_MHZ;
  localparam int CPU_READY_US = 2;
  localparam logic [7:0] CPU_READY_CYC = 8'(CPU_READY_US * CLK_MHZ);
  localparam logic [10:0] OST_CYCLES   = 11'h400;
  localparam logic [2:0] SW_OLD_TICKS  = 3'h2;
  localparam logic [2:0] SW_NEW_TICKS  = 3'h3;
  typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_SLEEP} pmcs_pm_t;
  typedef enum logic [1:0] {SW_IDLE, SW_OLD, SW_NEW} pmcs_sw_t;
endpackage

// >>> src/pmcs_top.sv
// Power-mode and device-clock source selector with APB registers.
// Assumes oscillator waves arrive asynchronously and are much slower than pclk.
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [RL1] Primary oscillator runs in primary idle; disabled in other managed modes.
// [RL2] Secondary modes clock the device from the secondary oscillator.
// [RL3] Internal modes clock the device from the internal oscillator block.
// [RL4] Slow internal oscillator usable as clock, enableable for watchdog anytime.
// [RL5] Fast internal oscillator clocks directly or through a postscaler.
// [RL6] Fast internal output off while slow internal clocks device directly.
// [RL7] Sleep stops every device clock; the secondary and the watchdog's slow oscillator keep running.
// [RL8] Slow internal oscillator keeps running while watchdog operates.
// [RL9] Fixed power-up delay active only when its enable bit is zero.
// [RL10] Crystal modes hold reset until 1024 oscillator cycles counted.
// [RL11] PLL mode holds reset an extra 2 ms after start-up count.
// [RL12] Processor-ready delay runs concurrently after power-on.
// [RL13] Clock-out pin held low in sleep for RC, internal-clockout, external modes.
// [RL14] I/O modes give clock-out pin to port bit 6, internal-all-io adds bit 7.
// [RL15] Control register top bit picks idle, two low bits pick source.
// [RL16] Select 00 primary, 01 secondary, 1x internal block.
// [RL17] Select change switches at once to running source after transition delay.
// [RL18] Sleep instruction enters sleep if idle bit zero, else idle mode.
// [RL19] Glitch-free switch pauses two old plus three new source cycles.
// [RL20] Primary-ready and secondary-running flags show the driving source.
// [RL21] Internal-stable flag set when fast internal output is stable and used.
// [RL22] At most one source flag normally set; none means slow or unstable.
// [RL23] Internal primary may show both flags; internal mode clears primary-ready.
// [RL24] Every reset clears source select bits.
// [RL25] Secondary select ignored unless secondary oscillator enable set.
// [RL26] Frequency select 111 undivided, lower halves, 000 slow, reset 1 MHz.
// [RL27] Source flags read-only, updated on switch completion or stability.
module pmcs_top #(
  parameter int POWER_UP_DELAY_TIMER_CYC = pmcs_pkg::POWER_UP_DELAY_TIMER_CYC,
  parameter int PLL_CYC  = pmcs_pkg::PLL_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sleep_exec,
  input  wire logic        wake_event,
  input  wire logic        prim_osc_wave,
  input  wire logic        sec_osc_wave,
  input  wire logic        fast_int_wave,
  input  wire logic        slow_int_wave,
  input  wire logic        fast_int_ready,
  input  wire logic        port6_out,
  input  wire logic        port6_oe,
  input  wire logic        port7_out,
  input  wire logic        port7_oe,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             device_reset_hold,
  output logic             prim_osc_en,
  output logic             sec_osc_en,
  output logic             fast_int_en,
  output logic             slow_int_en,
  output logic             osc_pin_in_o,
  output logic             osc_pin_in_oe,
  output logic             osc_pin_out_o,
  output logic             osc_pin_out_oe
);
  // Registers
  logic                 idle_enable_bit;
  logic [2:0]           internal_freq_select;
  logic [1:0]           source_select_bits;
  logic                 secondary_osc_enable;
  logic [3:0]           primary_osc_config;
  logic                 power_up_delay_enable_n;
  logic                 watchdog_enable;
  logic                 primary_ready_flag;
  logic                 internal_stable_flag;
  logic                 secondary_running_flag;
  // State
  pmcs_pkg::pmcs_pm_t   pm;
  pmcs_pkg::pmcs_sw_t   sw;
  logic [1:0]           cur_src;
  logic [1:0]           new_src;
  logic [2:0]           sw_cnt;
  logic [4:0]           sync_a;
  logic [4:0]           sync_b;
  logic [3:0]           wave_d;
  logic [6:0]           div_cnt;
  logic [10:0]          ost_cnt;
  logic [17:0]          pll_cnt;
  logic [12:0]          power_up_delay_timer_cnt;
  logic [7:0]           cpu_cnt;
  logic                 por_done;
  logic [1:0]           clk4_cnt;

  // Oscillator waves are asynchronous; edges are found after two stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
      wave_d <= 4'h0;
    end else begin
      sync_a <= {fast_int_ready, slow_int_wave, fast_int_wave, sec_osc_wave, prim_osc_wave};
      sync_b <= sync_a;
      wave_d <= sync_b[3:0];
    end
  end

  wire [3:0] tick       = sync_b[3:0] & ~wave_d;
  wire       prim_tick  = tick[0];
  wire       sec_tick   = tick[1];
  wire       fast_tick  = tick[2];
  wire       slow_tick  = tick[3];
  wire       fast_ready = sync_b[4];

  // Postscaler: mask halves frequency for each step below 111
  wire [6:0] div_mask   = 7'h7F >> internal_freq_select;
  wire       slow_sel   = internal_freq_select == pmcs_pkg::FREQ_SLOW;
  wire       int_tick   = slow_sel ? slow_tick : (fast_tick && (div_cnt & div_mask) == 7'h00); // RL4 RL5 RL26

  wire crystal    = primary_osc_config == pmcs_pkg::OSC_LP || primary_osc_config == pmcs_pkg::OSC_XT ||
                    primary_osc_config == pmcs_pkg::OSC_HS || primary_osc_config == pmcs_pkg::OSC_HIGH_SPEED_PLL_MODE;
  wire int_primary = primary_osc_config == pmcs_pkg::OSC_INTERNAL_CLOCKOUT_MODE || primary_osc_config == pmcs_pkg::OSC_INTERNAL_ALL_IO_MODE;
  wire ost_done   = !crystal || ost_cnt == pmcs_pkg::OST_CYCLES; // RL10
  wire pll_done   = primary_osc_config != pmcs_pkg::OSC_HIGH_SPEED_PLL_MODE || pll_cnt == 18'(PLL_CYC); // RL11
  wire power_up_delay_timer_done  = power_up_delay_enable_n || power_up_delay_timer_cnt == 13'(POWER_UP_DELAY_TIMER_CYC); // RL9
  wire cpu_done   = cpu_cnt == pmcs_pkg::CPU_READY_CYC; // RL12
  wire pri_ready  = ost_done && pll_done;
  wire pri_tick   = int_primary ? int_tick : prim_tick;

  // Source decode
  wire [1:0] req_src  = source_select_bits[1] ? pmcs_pkg::SRC_INT :
                        (source_select_bits[0] ? pmcs_pkg::SRC_SEC : pmcs_pkg::SRC_PRI); // RL16
  wire sw_busy  = sw != pmcs_pkg::SW_IDLE;
  wire asleep   = pm == pmcs_pkg::PM_SLEEP;
  wire sw_start = !sw_busy && req_src != cur_src && !asleep && por_done; // RL17
  wire cur_tick = cur_src == pmcs_pkg::SRC_PRI ? pri_tick :
                  (cur_src == pmcs_pkg::SRC_SEC ? sec_tick : int_tick); // RL2 RL3
  wire new_tick = new_src == pmcs_pkg::SRC_PRI ? (pri_tick && pri_ready) :
                  (new_src == pmcs_pkg::SRC_SEC ? sec_tick : int_tick);
  wire cur_ok   = cur_src != pmcs_pkg::SRC_PRI || pri_ready;
  wire dev_tick = !asleep && !sw_busy && por_done && cur_ok && cur_tick; // RL7 RL19

  // Oscillator enables
  wire uses_pri = cur_src == pmcs_pkg::SRC_PRI || (sw_busy && new_src == pmcs_pkg::SRC_PRI);
  wire uses_int = cur_src == pmcs_pkg::SRC_INT || (sw_busy && new_src == pmcs_pkg::SRC_INT) ||
                  (int_primary && uses_pri);
  assign prim_osc_en   = !asleep && uses_pri && !int_primary; // RL1 RL7
  assign sec_osc_en    = secondary_osc_enable;
  assign fast_int_en   = !asleep && uses_int && !slow_sel; // RL5 RL6
  assign slow_int_en   = watchdog_enable || (!asleep && uses_int && slow_sel); // RL4 RL8
  assign cpu_clk_en    = dev_tick && pm == pmcs_pkg::PM_RUN; // RL18
  assign periph_clk_en = dev_tick;
  assign device_reset_hold = !por_done;

  // Pins in the chosen primary mode
  wire clkout_mode = primary_osc_config == pmcs_pkg::OSC_RC || primary_osc_config == pmcs_pkg::OSC_INTERNAL_CLOCKOUT_MODE ||
                     primary_osc_config == pmcs_pkg::OSC_EC;
  wire io6_mode    = primary_osc_config == pmcs_pkg::OSC_RESISTOR_CAPACITOR_IO_MODE || primary_osc_config == pmcs_pkg::OSC_EXTERNAL_CLOCK_IO_MODE ||
                     primary_osc_config == pmcs_pkg::OSC_INTERNAL_ALL_IO_MODE;
  assign osc_pin_out_o  = io6_mode ? port6_out : (clkout_mode && !asleep && clk4_cnt[1]); // RL13 RL14
  assign osc_pin_out_oe = io6_mode ? port6_oe : clkout_mode;
  assign osc_pin_in_o   = primary_osc_config == pmcs_pkg::OSC_INTERNAL_ALL_IO_MODE && port7_out; // RL14
  assign osc_pin_in_oe  = primary_osc_config == pmcs_pkg::OSC_INTERNAL_ALL_IO_MODE && port7_oe;

  // APB decode; slave always ready, answers in the access cycle
  wire setup    = psel && !penable;
  wire wr       = psel && penable && pwrite;
  wire hit_ctrl = paddr == pmcs_pkg::OSC_CTRL_ADDR;
  wire hit_t1   = paddr == pmcs_pkg::TIMER1_CTRL_ADDR;
  wire hit_cfg  = paddr == pmcs_pkg::CONFIG_ADDR;
  wire hit_stat = paddr == pmcs_pkg::STATUS_ADDR;
  wire mapped   = hit_ctrl || hit_t1 || hit_cfg || hit_stat;
  wire [1:0] wsel = pwdata[1:0];
  // Secondary request dropped while its oscillator is off
  wire [1:0] next_sel = (wsel == pmcs_pkg::SRC_SEC && !secondary_osc_enable) ? source_select_bits : wsel; // RL25
  wire [31:0] rd_data =
    hit_ctrl ? {24'h000000, idle_enable_bit, internal_freq_select, primary_ready_flag,
                internal_stable_flag, source_select_bits} :
    hit_t1   ? {25'h0000000, secondary_running_flag, 2'h0, secondary_osc_enable, 3'h0} :
    hit_cfg  ? {26'h0000000, watchdog_enable, power_up_delay_enable_n, primary_osc_config} :
    hit_stat ? {24'h000000, sw_busy, por_done, 2'h0, 2'(pm), cur_src} : 32'h00000000;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      prdata <= rd_data;
    end
  end

  // Writable fields; flags are not written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_enable_bit         <= 1'b0;
      internal_freq_select    <= pmcs_pkg::FREQ_RESET; // RL26
      source_select_bits      <= pmcs_pkg::SEL_RESET; // RL24
      secondary_osc_enable    <= 1'b0;
      primary_osc_config      <= pmcs_pkg::CFG_OSC_RESET;
      power_up_delay_enable_n <= pmcs_pkg::POWER_UP_DELAY_TIMER_EN_N_RESET;
      watchdog_enable         <= pmcs_pkg::WDT_EN_RESET;
    end else if (wr && hit_ctrl) begin
      idle_enable_bit      <= pwdata[pmcs_pkg::IDLE_EN_POS]; // RL15
      internal_freq_select <= pwdata[pmcs_pkg::FREQ_LSB +: 3];
      source_select_bits   <= next_sel; // RL15 RL25
    end else if (wr && hit_t1) begin
      secondary_osc_enable <= pwdata[pmcs_pkg::SEC_OSC_EN_POS];
    end else if (wr && hit_cfg) begin
      primary_osc_config      <= pwdata[3:0];
      power_up_delay_enable_n <= pwdata[pmcs_pkg::POWER_UP_DELAY_TIMER_EN_N_POS];
      watchdog_enable         <= pwdata[pmcs_pkg::WDT_EN_POS];
    end
  end

  // Power-on delays run side by side; the longest one releases reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_up_delay_timer_cnt <= 13'h0000;
      cpu_cnt  <= 8'h00;
      por_done <= 1'b0;
    end else begin
      if (!power_up_delay_timer_done) begin
        power_up_delay_timer_cnt <= power_up_delay_timer_cnt + 13'h0001; // RL9
      end
      if (!cpu_done) begin
        cpu_cnt <= cpu_cnt + 8'h01; // RL12
      end
      if (power_up_delay_timer_done && cpu_done && pri_ready) begin
        por_done <= 1'b1; // RL10 RL11 RL12
      end
    end
  end

  // Start-up count restarts whenever the primary is stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ost_cnt <= 11'h000;
      pll_cnt <= 18'h00000;
    end else begin
      if (!prim_osc_en) begin
        ost_cnt <= 11'h000;
      end else if (!ost_done && prim_tick) begin
        ost_cnt <= ost_cnt + 11'h001; // RL10
      end
      if (!prim_osc_en || !ost_done) begin
        pll_cnt <= 18'h00000;
      end else if (!pll_done) begin
        pll_cnt <= pll_cnt + 18'h00001; // RL11
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt  <= 7'h00;
      clk4_cnt <= 2'h0;
    end else begin
      if (fast_tick) begin
        div_cnt <= div_cnt + 7'h01; // RL5
      end
      if (dev_tick) begin
        clk4_cnt <= clk4_cnt + 2'h1;
      end
    end
  end

  // Power mode; idle bit is sampled at the sleep instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm <= pmcs_pkg::PM_RUN;
    end else begin
      case (pm)
        pmcs_pkg::PM_RUN: begin
          if (sleep_exec) begin
            pm <= idle_enable_bit ? pmcs_pkg::PM_IDLE : pmcs_pkg::PM_SLEEP; // RL18
          end
        end
        pmcs_pkg::PM_IDLE, pmcs_pkg::PM_SLEEP: begin
          if (wake_event) begin
            pm <= pmcs_pkg::PM_RUN;
          end
        end
        default: pm <= pmcs_pkg::PM_RUN;
      endcase
    end
  end

  // Switch: drain old source, then fill from the new one; clock held meanwhile
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw      <= pmcs_pkg::SW_IDLE;
      cur_src <= pmcs_pkg::SRC_PRI;
      new_src <= pmcs_pkg::SRC_PRI;
      sw_cnt  <= 3'h0;
    end else begin
      case (sw)
        pmcs_pkg::SW_IDLE: begin
          if (sw_start) begin
            sw      <= pmcs_pkg::SW_OLD; // RL17
            new_src <= req_src;
            sw_cnt  <= 3'h0;
          end
        end
        pmcs_pkg::SW_OLD: begin
          if (cur_tick || !cur_ok) begin
            sw_cnt <= sw_cnt + 3'h1;
          end
          if (sw_cnt == pmcs_pkg::SW_OLD_TICKS) begin
            sw     <= pmcs_pkg::SW_NEW; // RL19
            sw_cnt <= 3'h0;
          end
        end
        pmcs_pkg::SW_NEW: begin
          if (new_tick) begin
            sw_cnt <= sw_cnt + 3'h1;
          end
          if (sw_cnt == pmcs_pkg::SW_NEW_TICKS) begin
            sw      <= pmcs_pkg::SW_IDLE; // RL19
            cur_src <= new_src;
          end
        end
        default: sw <= pmcs_pkg::SW_IDLE;
      endcase
    end
  end

  // Flags follow the settled source; sleep clears them all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_ready_flag     <= 1'b0;
      internal_stable_flag   <= 1'b0;
      secondary_running_flag <= 1'b0;
    end else begin
      primary_ready_flag     <= !asleep && !sw_busy && cur_src == pmcs_pkg::SRC_PRI && pri_ready; // RL20 RL23 RL27
      secondary_running_flag <= !asleep && !sw_busy && cur_src == pmcs_pkg::SRC_SEC; // RL20 RL22 RL27
      internal_stable_flag   <= !asleep && !sw_busy && fast_int_en && fast_ready &&
                                (cur_src == pmcs_pkg::SRC_INT || int_primary); // RL21 RL22 RL23
    end
  end

  // Checks
  sequence s_switch_pause;
    !periph_clk_en [*3];
  endsequence

  property p_sec_ignored;
    @(posedge pclk) disable iff (!presetn)
      wr && hit_ctrl && wsel == pmcs_pkg::SRC_SEC && !secondary_osc_enable |=> $stable(source_select_bits);
  endproperty
  a_sec_ignored: assert property (p_sec_ignored) else $error("secondary select taken while disabled"); // RL25

  property p_sleep_dark;
    @(posedge pclk) disable iff (!presetn)
      asleep |-> !periph_clk_en && !cpu_clk_en && !prim_osc_en && !fast_int_en;
  endproperty
  a_sleep_dark: assert property (p_sleep_dark) else $error("clock active in sleep"); // RL7

  property p_prim_off;
    @(posedge pclk) disable iff (!presetn)
      !sw_busy && cur_src != pmcs_pkg::SRC_PRI |-> !prim_osc_en;
  endproperty
  a_prim_off: assert property (p_prim_off) else $error("primary on in other mode"); // RL1

  property p_fast_off;
    @(posedge pclk) disable iff (!presetn)
      slow_sel && cur_src == pmcs_pkg::SRC_INT |-> !fast_int_en;
  endproperty
  a_fast_off: assert property (p_fast_off) else $error("fast internal on with slow source"); // RL6

  property p_wdt_slow;
    @(posedge pclk) disable iff (!presetn)
      watchdog_enable |-> slow_int_en;
  endproperty
  a_wdt_slow: assert property (p_wdt_slow) else $error("slow oscillator off under watchdog"); // RL8

  property p_sleep_entry;
    @(posedge pclk) disable iff (!presetn)
      pm == pmcs_pkg::PM_RUN && sleep_exec |=>
        (pm == ($past(idle_enable_bit) ? pmcs_pkg::PM_IDLE : pmcs_pkg::PM_SLEEP)) ##1 !cpu_clk_en;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("wrong mode after sleep instruction"); // RL18

  property p_switch_pause;
    @(posedge pclk) disable iff (!presetn)
      sw_start |=> s_switch_pause;
  endproperty
  a_switch_pause: assert property (p_switch_pause) else $error("clock ran during switch"); // RL19

  property p_decode;
    @(posedge pclk) disable iff (!presetn)
      !sw_busy && !sw_start && por_done && source_select_bits[1] |-> cur_src == pmcs_pkg::SRC_INT;
  endproperty
  a_decode: assert property (p_decode) else $error("select decode mismatch"); // RL16

  property p_onehot;
    @(posedge pclk) disable iff (!presetn)
      $onehot0({primary_ready_flag, secondary_running_flag}) &&
      !(secondary_running_flag && internal_stable_flag);
  endproperty
  a_onehot: assert property (p_onehot) else $error("several source flags set"); // RL22

  property p_clkout_low;
    @(posedge pclk) disable iff (!presetn)
      asleep && clkout_mode |-> osc_pin_out_oe && !osc_pin_out_o;
  endproperty
  a_clkout_low: assert property (p_clkout_low) else $error("clock-out pin not low in sleep"); // RL13

  property p_port6;
    @(posedge pclk) disable iff (!presetn)
      io6_mode |-> osc_pin_out_o == port6_out && osc_pin_out_oe == port6_oe;
  endproperty
  a_port6: assert property (p_port6) else $error("port bit 6 not routed"); // RL14
endmodule
`default_nettype wire

// >>> verification/pmcs_osc_model.sv
// Oscillator sources facing the clock selector.
// Assumes enables come from the selector; a stopped wave rests low.
`timescale 1ns/1ps
`default_nettype none
module pmcs_osc_model (
  input  wire logic prim_osc_en,
  input  wire logic sec_osc_en,
  input  wire logic fast_int_en,
  input  wire logic slow_int_en,
  output logic      prim_osc_wave,
  output logic      sec_osc_wave,
  output logic      fast_int_wave,
  output logic      slow_int_wave,
  output logic      fast_int_ready
);
  initial begin
    {prim_osc_wave, sec_osc_wave, fast_int_wave, slow_int_wave, fast_int_ready} = 5'h00;
  end
  // Periods unrelated to pclk, all above three pclk cycles
  always #23 prim_osc_wave = prim_osc_en & ~prim_osc_wave;
  always #57 sec_osc_wave = sec_osc_en & ~sec_osc_wave;
  always #21 fast_int_wave = fast_int_en & ~fast_int_wave;
  always #61 slow_int_wave = slow_int_en & ~slow_int_wave;
  // Settling time, so stability is never instant
  always @(fast_int_en) begin
    fast_int_ready = 1'b0;
    if (fast_int_en) #300 fast_int_ready = fast_int_en;
  end
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the power-mode clock selector.
// Assumes the oscillator model on the far side and an APB slave.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        sleep_exec, wake_event, port6_out, port6_oe, port7_out, port7_oe;
  logic        cpu_clk_en, periph_clk_en, device_reset_hold, prim_osc_en, sec_osc_en;
  logic        fast_int_en, slow_int_en, prim_osc_wave, sec_osc_wave, fast_int_wave;
  logic        slow_int_wave, fast_int_ready, osc_pin_in_o, osc_pin_in_oe, osc_pin_out_o, osc_pin_out_oe;
  logic [2:0]  f;
  int          error_cnt, cmp_count, nc, np, hold_cyc;
  int          seed = 32'h71E30ED0;
  pmcs_top #(.POWER_UP_DELAY_TIMER_CYC(20), .PLL_CYC(50)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sleep_exec, .wake_event, .prim_osc_wave, .sec_osc_wave,
    .fast_int_wave, .slow_int_wave, .fast_int_ready, .port6_out, .port6_oe, .port7_out, .port7_oe,
    .cpu_clk_en, .periph_clk_en, .device_reset_hold, .prim_osc_en, .sec_osc_en, .fast_int_en,
    .slow_int_en, .osc_pin_in_o, .osc_pin_in_oe, .osc_pin_out_o, .osc_pin_out_oe);
  pmcs_osc_model osc (.prim_osc_en, .sec_osc_en, .fast_int_en, .slow_int_en, .prim_osc_wave,
    .sec_osc_wave, .fast_int_wave, .slow_int_wave, .fast_int_ready);
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic tmo;
    error_cnt++;
    $display("unexpected at %0t: wait ran out", $time);
    end_of_test;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] ctrl_exp(logic idl, logic [2:0] fr, logic pr, logic st, logic [1:0] s);
    return {24'h000000, idl, fr, pr, st, s};
  endfunction
  // Fewest cycles: first tick may land at release, the rest one period apart
  function automatic int ost_cyc();
    return (int'(pmcs_pkg::OST_CYCLES) - 1) * 46 / 10;
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) tmo();
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic wait_sw;
    int i;
    repeat (3) @(posedge pclk);
    for (i = 0; i < 400; i++) begin
      apb(1'b0, pmcs_pkg::STATUS_ADDR, 32'h0);
      if (rdat[7] === 1'b0) break;
    end
    if (i == 400) tmo();
  endtask
  task automatic pulses(input int n);
    nc = 0;
    np = 0;
    repeat (n) begin
      @(negedge pclk);
      nc += int'(cpu_clk_en !== 1'b0);
      np += int'(periph_clk_en !== 1'b0);
    end
  endtask
  task automatic strobe(input logic s);
    @(posedge pclk);
    if (s) sleep_exec <= 1'b1;
    else wake_event <= 1'b1;
    @(posedge pclk);
    sleep_exec <= 1'b0;
    wake_event <= 1'b0;
  endtask
  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Sampled mid-cycle so the hold output has settled
    for (hold_cyc = 0; hold_cyc < 20000; hold_cyc++) begin
      @(negedge pclk);
      if (device_reset_hold === 1'b0) break;
    end
    if (hold_cyc == 20000) tmo();
  endtask
  initial begin
    {psel, penable, pwrite, sleep_exec, wake_event, presetn} = 6'h00;
    {port6_out, port6_oe, port7_out, port7_oe} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    do_reset;
    chk(32'(hold_cyc >= ost_cyc()), 32'h1);
    rchk(pmcs_pkg::OSC_CTRL_ADDR, ctrl_exp(1'b0, 3'h4, 1'b1, 1'b0, 2'h0));
    rchk(pmcs_pkg::CONFIG_ADDR, 32'h12);
    rchk(pmcs_pkg::STATUS_ADDR, 32'h40);
    rchk(8'h10, 32'h0);
    chk(32'(rerr), 32'h1);
    apb(1'b1, pmcs_pkg::OSC_CTRL_ADDR, 32'h45);
    rchk(pmcs_pkg::OSC_CTRL_ADDR, 32'h48);
    $display("test reset done");
    apb(1'b1, pmcs_pkg::TIMER1_CTRL_ADDR, 32'h08);
    apb(1'b1, pmcs_pkg::OSC_CTRL_ADDR, 32'h41);
    wait_sw;
    rchk(pmcs_pkg::STATUS_ADDR, 32'h41);
    rchk(pmcs_pkg::TIMER1_CTRL_ADDR, 32'h48);
    rchk(pmcs_pkg::OSC_CTRL_ADDR, ctrl_exp(1'b0, 3'h4, 1'b0, 1'b0, 2'h1));
    chk(32'(prim_osc_en), 32'h0);
    chk(32'(sec_osc_en), 32'h1);
    apb(1'b1, pmcs_pkg::OSC_CTRL_ADDR, 32'hC1);
    strobe(1'b1);
    pulses(100);
    chk(32'({nc == 0, np > 0}), 32'h3);
    rchk(pmcs_pkg::STATUS_ADDR, 32'h45);
    strobe(1'b0);
    pulses(100);
    chk(32'(nc > 0), 32'h1);
    $display("test secondary done");
    for (int k = 0; k < 3; k++) begin
      f = (k == 0) ? 3'h7 : (k == 1) ? 3'h0 : 3'($random(seed));
      apb(1'b1, pmcs_pkg::OSC_CTRL_ADDR, {24'h000000, 1'b0, f, 3'h1, k[0]});
      wait_sw;
      repeat (100) @(posedge pclk);
      rchk(pmcs_pkg::STATUS_ADDR, 32'h42);
      rchk(pmcs_pkg::OSC_CTRL_ADDR, ctrl_exp(1'b0, f, 1'b0, f != 3'h0, {1'b1, k[0]}));
      chk(32'(fast_int_en), 32'(f != 3'h0));
    end
    $display("test internal done");
    apb(1'b1, pmcs_pkg::CONFIG_ADDR, 32'h34);
    apb(1'b1, pmcs_pkg::OSC_CTRL_ADDR, 32'h72);
    wait_sw;
    strobe(1'b1);
    repeat (3) @(posedge pclk);
    pulses(50);
    chk(32'(nc + np), 32'h0);
    chk(32'({prim_osc_en, fast_int_en, slow_int_en, osc_pin_out_o, osc_pin_out_oe}), 32'h5);
    rchk(pmcs_pkg::OSC_CTRL_ADDR, ctrl_exp(1'b0, 3'h7, 1'b0, 1'b0, 2'h2));
    strobe(1'b0);
    $display("test sleep done");
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, pmcs_pkg::CONFIG_ADDR, k ? 32'h18 : 32'h15);
      {port6_out, port6_oe, port7_out, port7_oe} <= 4'($random(seed));
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk(32'({osc_pin_out_o, osc_pin_out_oe}), 32'({port6_out, port6_oe}));
      if (k) chk(32'({osc_pin_in_o, osc_pin_in_oe}), 32'({port7_out, port7_oe}));
    end
    $display("test pins done");
    do_reset;
    rchk(pmcs_pkg::OSC_CTRL_ADDR, 32'h48);
    $display("test second reset done");
    end_of_test;
  end
endmodule
`default_nettype wire
